// [src/drp_top.sv]
`timescale 1ns/1ps
`default_nettype none
module drp_top
  import drp_pkg::*;
#(
  parameter int HALF = DRP_HALF_CYC,
  parameter int PAIRS = DRP_PAIRS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic pulse_gen_busy,
  input wire logic driver_ready_in,
  input wire logic data_bit_low_in,
  input wire logic data_bit_high_in,
  output logic req_out,
  output logic transfer_clock_out,
  output logic position_data_ready_flag,
  output logic [7:0] tpdo_bits,
  output logic positive_soft_limit,
  output logic negative_soft_limit
);
  // byte-lane merge, shared by the ceiling, scale, feedback, commanded and encoder registers
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return old;
  endfunction : be_merge
  //////////////////////////////////////////////////////////////////////////////
  logic waitrequest_ff; // high except in the answer cycle
  logic [31:0] rdata_ff; // read data captured for the answer
  logic irq_ff;
  logic ready_ff; // position data ready flag
  logic busy_ff; // a read is in flight
  logic adopt_ff; // the in-flight read is an adopt
  logic [31:0] rpos_ff; // remote position value
  logic [15:0] rsts_ff; // remote status/alarm word
  logic [31:0] cpos_ff; // commanded position
  logic [31:0] fpos_ff; // feedback position
  logic [31:0] enc_ff; // encoder count
  logic [7:0] cfg_ff; // action, energized, mapping
  logic [31:0] ceil_ff; // position ceiling
  logic [15:0] scale_ff; // milli-units per driver step
  logic [DRP_IRQ_W-1:0] ists_ff;
  logic [DRP_IRQ_W-1:0] imsk_ff;
  logic home_ff; // electrical home has been set
  logic positive_soft_limit_ff;
  logic negative_soft_limit_ff;
  logic [7:0] tpdo_ff;
  logic acc; // bus transfer completes this edge
  logic wr;
  logic rd;
  logic cmd_plain;
  logic cmd_adopt;
  logic start; // command accepted
  logic reject; // adopt refused during pulse output
  logic link_done;
  logic link_req;
  logic link_clk;
  drp_frame_t frame;
  logic [31:0] user_pos;
  logic [31:0] clamp_pos;
  logic [31:0] dev; // commanded minus feedback
  logic [31:0] nxt_fpos;
  logic [31:0] nxt_fpos_c;
  logic energized;
  logic [31:0] rd_mux;
  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign acc = (avs_read | avs_write) & ~waitrequest_ff;
  assign wr = acc & avs_write;
  assign rd = acc & avs_read;
  assign energized = cfg_ff[DRP_CFG_ENERG];
  assign cmd_plain = wr && avs_address == DRP_REG_CMD && avs_byteenable[0] && avs_writedata[DRP_CMD_PLAIN];
  assign cmd_adopt = wr && avs_address == DRP_REG_CMD && avs_byteenable[0] && avs_writedata[DRP_CMD_ADOPT];
  // [RQ10] adopt refused in pulse output
  assign reject = cmd_adopt && pulse_gen_busy;
  // a command while busy is dropped; adopt wins when both bits are written, except during pulse output, where the plain read starts
  assign start = !busy_ff && ((cmd_adopt && !pulse_gen_busy) || cmd_plain);
  //////////////////////////////////////////////////////////////////////////////
  // avalon handshake: one wait cycle, then answer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest_ff <= 1'b1;
      rdata_ff <= '0;
    end else begin
      waitrequest_ff <= !((avs_read | avs_write) && waitrequest_ff);
      if ((avs_read | avs_write) && waitrequest_ff) begin
        rdata_ff <= avs_read ? rd_mux : 32'h0;
      end
    end
  end
  // read mux, unmapped reads zero
  always_comb begin
    unique case (avs_address)
      DRP_REG_STAT: rd_mux = {25'h0, pulse_gen_busy, negative_soft_limit_ff, positive_soft_limit_ff, home_ff, adopt_ff, busy_ff, ready_ff};
      DRP_REG_RPOS: rd_mux = rpos_ff;
      DRP_REG_RSTS: rd_mux = {16'h0, rsts_ff};
      DRP_REG_CPOS: rd_mux = cpos_ff;
      DRP_REG_FPOS: rd_mux = fpos_ff;
      DRP_REG_ENC: rd_mux = enc_ff;
      DRP_REG_CFG: rd_mux = {24'h0, cfg_ff};
      DRP_REG_CEIL: rd_mux = ceil_ff;
      DRP_REG_SCALE: rd_mux = {16'h0, scale_ff};
      DRP_REG_ISTS: rd_mux = {30'h0, ists_ff};
      DRP_REG_IMSK: rd_mux = {30'h0, imsk_ff};
      default: rd_mux = 32'h0;
    endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  // [RQ14] driver position link
  drp_link #(.HALF(HALF), .PAIRS(PAIRS)) u_link (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(start),
    .driver_ready_in(driver_ready_in),
    .data_bit_low_in(data_bit_low_in),
    .data_bit_high_in(data_bit_high_in),
    .req_out(link_req),
    .transfer_clock_out(link_clk),
    .done(link_done),
    .frame(frame)
  );
  assign req_out = link_req;
  assign transfer_clock_out = link_clk;
  // [RQ2] user unit conversion
  drp_scale u_scale (
    .steps(frame.pos),
    .scale(scale_ff),
    .ceil(ceil_ff),
    .user(user_pos),
    .clamped(clamp_pos)
  );
  //////////////////////////////////////////////////////////////////////////////
  // config registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= DRP_CFG_RST;
      ceil_ff <= DRP_CEIL_RST;
      scale_ff <= DRP_SCALE_RST;
      imsk_ff <= '0;
    end else if (wr) begin
      if (avs_address == DRP_REG_CFG && avs_byteenable[0]) begin
        cfg_ff <= avs_writedata[7:0];
      end
      if (avs_address == DRP_REG_CEIL) begin
        ceil_ff <= be_merge(ceil_ff, avs_writedata, avs_byteenable);
      end
      if (avs_address == DRP_REG_SCALE) begin
        scale_ff <= 16'(be_merge({16'h0, scale_ff}, avs_writedata, avs_byteenable));
      end
      if (avs_address == DRP_REG_IMSK && avs_byteenable[0]) begin
        imsk_ff <= avs_writedata[DRP_IRQ_W-1:0];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // command tracking and ready flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      adopt_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else if (start) begin
      busy_ff <= 1'b1;
      adopt_ff <= cmd_adopt && !pulse_gen_busy;
      // [RQ15] clear ready on accept
      ready_ff <= 1'b0;
    end else if (link_done) begin
      busy_ff <= 1'b0;
      // [RQ11] ready after storing
      ready_ff <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // [RQ1] store fetched results
  // [RQ6] held until next read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rpos_ff <= '0;
      rsts_ff <= '0;
    end else if (link_done) begin
      rpos_ff <= user_pos;
      // [RQ5] status high, alarm low
      rsts_ff <= {frame.status, frame.alarm};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // position registers; feedback and encoder come from software writes here
  assign dev = cpos_ff - fpos_ff;
  assign nxt_fpos = clamp_pos - dev;
  // [RQ9] feedback kept in range too
  assign nxt_fpos_c = ($signed(nxt_fpos) > $signed(ceil_ff)) ? ceil_ff :
                      ($signed(nxt_fpos) < -$signed(ceil_ff)) ? -ceil_ff : nxt_fpos;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpos_ff <= '0;
      fpos_ff <= '0;
      enc_ff <= '0;
    end else if (link_done && adopt_ff) begin
      // [RQ3] adopt keeping deviation
      cpos_ff <= energized ? clamp_pos : nxt_fpos_c;
      fpos_ff <= energized ? nxt_fpos_c : nxt_fpos_c;
      enc_ff <= enc_ff + (nxt_fpos_c - fpos_ff);
    end else begin
      if (wr && avs_address == DRP_REG_FPOS) begin
        fpos_ff <= be_merge(fpos_ff, avs_writedata, avs_byteenable);
      end
      if (wr && avs_address == DRP_REG_ENC) begin
        enc_ff <= be_merge(enc_ff, avs_writedata, avs_byteenable);
      end
      // [RQ7] zero deviation when off
      if (!energized) begin
        cpos_ff <= (wr && avs_address == DRP_REG_FPOS) ? be_merge(fpos_ff, avs_writedata, avs_byteenable) : fpos_ff;
      end else if (wr && avs_address == DRP_REG_CPOS) begin
        cpos_ff <= be_merge(cpos_ff, avs_writedata, avs_byteenable);
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // [RQ4] home and soft limits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      home_ff <= 1'b0;
      positive_soft_limit_ff <= 1'b0;
      negative_soft_limit_ff <= 1'b0;
    end else if (link_done && adopt_ff && cfg_ff[DRP_CFG_SOFT_LIMIT_ACTION]) begin
      home_ff <= 1'b1;
      positive_soft_limit_ff <= 1'b1;
      negative_soft_limit_ff <= 1'b1;
    end
  end
  assign positive_soft_limit = positive_soft_limit_ff;
  assign negative_soft_limit = negative_soft_limit_ff;
  //////////////////////////////////////////////////////////////////////////////
  // [RQ12] ready flag onto remote bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tpdo_ff <= '0;
    end else begin
      tpdo_ff <= '0;
      if (cfg_ff[DRP_CFG_MAPEN]) begin
        tpdo_ff[cfg_ff[DRP_CFG_MAPLO +: 3]] <= ready_ff;
      end
    end
  end
  assign tpdo_bits = tpdo_ff;
  assign position_data_ready_flag = ready_ff;
  //////////////////////////////////////////////////////////////////////////////
  // sticky events; a read clears only the bits it returned, so an event landing in the wait cycle survives
  // a new event still wins over the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ists_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      ists_ff <= (ists_ff & ~((rd && avs_address == DRP_REG_ISTS) ? rdata_ff[DRP_IRQ_W-1:0] : {DRP_IRQ_W{1'b0}}))
                 | {reject, link_done};
      irq_ff <= |(ists_ff & imsk_ff);
    end
  end
  assign irq = irq_ff;
  assign avs_waitrequest = waitrequest_ff;
  assign avs_readdata = rdata_ff;
  //////////////////////////////////////////////////////////////////////////////
  property p_ready_clr;
    @(posedge ref_clk) disable iff (!rst_n) start |=> !ready_ff ##0 busy_ff;
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared on accept"); // [RQ15]
  property p_ready_set;
    @(posedge ref_clk) disable iff (!rst_n) link_done |=> ready_ff && !busy_ff;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not raised on completion"); // [RQ11]
  property p_reject;
    @(posedge ref_clk) disable iff (!rst_n) reject |=> ists_ff[DRP_IRQ_REJ] && !(busy_ff && adopt_ff && $rose(busy_ff));
  endproperty
  a_reject: assert property (p_reject) else $error("adopt during pulse output not rejected"); // [RQ10]
  property p_word;
    @(posedge ref_clk) disable iff (!rst_n) link_done |=> rsts_ff == {$past(frame.status), $past(frame.alarm)};
  endproperty
  a_word: assert property (p_word) else $error("status/alarm word wrong"); // [RQ5]
  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n) !link_done |=> $stable(rpos_ff) && $stable(rsts_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("stored values changed"); // [RQ6]
  property p_zero_dev;
    @(posedge ref_clk) disable iff (!rst_n) !energized |=> cpos_ff == fpos_ff;
  endproperty
  a_zero_dev: assert property (p_zero_dev) else $error("deviation not zero while off"); // [RQ7]
  property p_adopt;
    @(posedge ref_clk) disable iff (!rst_n)
      (link_done && adopt_ff && energized && nxt_fpos == nxt_fpos_c) |=> cpos_ff == $past(clamp_pos)
      && (cpos_ff - fpos_ff) == $past(dev);
  endproperty
  a_adopt: assert property (p_adopt) else $error("adopt lost deviation"); // [RQ3]
  property p_limits;
    @(posedge ref_clk) disable iff (!rst_n) (link_done && adopt_ff && cfg_ff[DRP_CFG_SOFT_LIMIT_ACTION]) |=> positive_soft_limit_ff && negative_soft_limit_ff && home_ff;
  endproperty
  a_limits: assert property (p_limits) else $error("soft limits not enabled"); // [RQ4]
  property p_tpdo;
    @(posedge ref_clk) disable iff (!rst_n) cfg_ff[DRP_CFG_MAPEN] ##1 $stable(cfg_ff) |-> tpdo_ff[cfg_ff[DRP_CFG_MAPLO +: 3]] == $past(ready_ff);
  endproperty
  a_tpdo: assert property (p_tpdo) else $error("mapped remote bit wrong"); // [RQ12]
  property p_ceil;
    @(posedge ref_clk) disable iff (!rst_n) (link_done && adopt_ff && !ceil_ff[31]) |=>
      $signed(cpos_ff) <= $signed(ceil_ff) && $signed(cpos_ff) >= -$signed(ceil_ff);
  endproperty
  a_ceil: assert property (p_ceil) else $error("adopted position above ceiling"); // [RQ9]
  c_plain: cover property (@(posedge ref_clk) disable iff (!rst_n) link_done && !adopt_ff);
  c_adopt: cover property (@(posedge ref_clk) disable iff (!rst_n) link_done && adopt_ff && cfg_ff[DRP_CFG_SOFT_LIMIT_ACTION]);
  c_reject: cover property (@(posedge ref_clk) disable iff (!rst_n) reject);
endmodule : drp_top
`default_nettype wire

// [src/drp_pkg.sv]
// Overview of operation
// [RQ1] plain read fetches position, status, alarm
// [RQ2] store converted position and status/alarm word
// [RQ3] adopt replaces commanded, shifts feedback and encoder
// [RQ4] soft limit action one sets home, limits
// [RQ5] word holds status high, alarm low
// [RQ6] stored values stay readable after completion
// [RQ7] de-energized drive forces deviation to zero
// [RQ8] accept full signed 32-bit milli-unit range
// [RQ9] adopted positions clamped to position ceiling
// [RQ10] adopt rejected while pulse generation runs
// [RQ11] ready flag rises on completion
// [RQ12] ready flag mappable onto remote output bit
// [RQ13] host de-energizes drive around the read
// [RQ14] link: request, clock out; ready, two bits in
// [RQ15] new command clears ready flag first
package drp_pkg;
  // register byte offsets
  localparam logic [5:0] DRP_REG_CMD = 6'h00;
  localparam logic [5:0] DRP_REG_STAT = 6'h04;
  localparam logic [5:0] DRP_REG_RPOS = 6'h08;
  localparam logic [5:0] DRP_REG_RSTS = 6'h0c;
  localparam logic [5:0] DRP_REG_CPOS = 6'h10;
  localparam logic [5:0] DRP_REG_FPOS = 6'h14;
  localparam logic [5:0] DRP_REG_ENC = 6'h18;
  localparam logic [5:0] DRP_REG_CFG = 6'h1c;
  localparam logic [5:0] DRP_REG_CEIL = 6'h20;
  localparam logic [5:0] DRP_REG_SCALE = 6'h24;
  localparam logic [5:0] DRP_REG_ISTS = 6'h28;
  localparam logic [5:0] DRP_REG_IMSK = 6'h2c;
  // command bits
  localparam int DRP_CMD_PLAIN = 0;
  localparam int DRP_CMD_ADOPT = 1;
  // config fields
  localparam int DRP_CFG_SOFT_LIMIT_ACTION = 0;
  localparam int DRP_CFG_ENERG = 1;
  localparam int DRP_CFG_MAPEN = 3;
  localparam int DRP_CFG_MAPLO = 4;
  // interrupt bits
  localparam int DRP_IRQ_DONE = 0;
  localparam int DRP_IRQ_REJ = 1;
  localparam int DRP_IRQ_W = 2;
  // reset values
  localparam logic [31:0] DRP_CEIL_RST = 32'h7fffffff;
  localparam logic [15:0] DRP_SCALE_RST = 16'h0001;
  localparam logic [7:0] DRP_CFG_RST = 8'h00;
  // link timing
  localparam int DRP_CLK_NS = 40;
  localparam int DRP_HALF_NS = 1000;
  localparam int DRP_HALF_CYC = (DRP_HALF_NS + DRP_CLK_NS - 1) / DRP_CLK_NS;
  localparam int DRP_PAIRS = 24;
  // one fetched frame from the driver
  typedef struct packed {
    logic [31:0] pos;
    logic [7:0] status;
    logic [7:0] alarm;
  } drp_frame_t;
endpackage : drp_pkg

// [src/drp_link.sv]
`timescale 1ns/1ps
`default_nettype none
module drp_link
  import drp_pkg::*;
#(
  parameter int HALF = DRP_HALF_CYC,
  parameter int PAIRS = DRP_PAIRS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic driver_ready_in,
  input wire logic data_bit_low_in,
  input wire logic data_bit_high_in,
  output logic req_out,
  output logic transfer_clock_out,
  output logic done,
  output drp_frame_t frame
);
  typedef enum logic [3:0] {
    DRP_L_IDLE = 4'b0001,
    DRP_L_WAIT = 4'b0010,
    DRP_L_HI = 4'b0100,
    DRP_L_LO = 4'b1000
  } drp_lstate_t;
  drp_lstate_t state_ff; // link sequencer
  logic [$clog2(HALF+1)-1:0] tmr_ff; // half-period timer
  logic [$clog2(PAIRS+1)-1:0] pair_ff; // pairs still due
  logic [2*PAIRS-1:0] sh_ff; // lsb pair first
  logic tmr_end;
  assign tmr_end = (tmr_ff == '0);
  //////////////////////////////////////////////////////////////////////////////
  // sequencer: request, wait ready, clock out pairs
  // [RQ14] request and clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= DRP_L_IDLE;
      req_out <= 1'b0;
      transfer_clock_out <= 1'b0;
      done <= 1'b0;
      tmr_ff <= '0;
      pair_ff <= '0;
      sh_ff <= '0;
    end else begin
      done <= 1'b0;
      tmr_ff <= tmr_end ? tmr_ff : tmr_ff - 1'b1;
      unique case (state_ff)
        DRP_L_IDLE: begin
          if (start) begin
            req_out <= 1'b1;
            state_ff <= DRP_L_WAIT;
            pair_ff <= PAIRS[$bits(pair_ff)-1:0];
          end
        end
        DRP_L_WAIT: begin
          // driver says its frame is latched
          if (driver_ready_in) begin
            transfer_clock_out <= 1'b1;
            tmr_ff <= HALF[$bits(tmr_ff)-1:0] - 1'b1;
            state_ff <= DRP_L_HI;
          end
        end
        DRP_L_HI: begin
          // sample at the end of the high phase, data had a half period to settle
          if (tmr_end) begin
            sh_ff <= {data_bit_high_in, data_bit_low_in, sh_ff[2*PAIRS-1:2]};
            transfer_clock_out <= 1'b0;
            pair_ff <= pair_ff - 1'b1;
            tmr_ff <= HALF[$bits(tmr_ff)-1:0] - 1'b1;
            state_ff <= DRP_L_LO;
          end
        end
        DRP_L_LO: begin
          if (tmr_end) begin
            if (pair_ff == '0) begin
              req_out <= 1'b0;
              done <= 1'b1;
              state_ff <= DRP_L_IDLE;
            end else begin
              transfer_clock_out <= 1'b1;
              tmr_ff <= HALF[$bits(tmr_ff)-1:0] - 1'b1;
              state_ff <= DRP_L_HI;
            end
          end
        end
      endcase
    end
  end
  assign frame = sh_ff;
  //////////////////////////////////////////////////////////////////////////////
  property p_clk_in_req;
    @(posedge ref_clk) disable iff (!rst_n) transfer_clock_out |-> req_out;
  endproperty
  a_clk_in_req: assert property (p_clk_in_req) else $error("clock outside request"); // [RQ14]
  property p_req_start;
    @(posedge ref_clk) disable iff (!rst_n) (state_ff == DRP_L_IDLE && start) |=> req_out && !transfer_clock_out;
  endproperty
  a_req_start: assert property (p_req_start) else $error("request not raised"); // [RQ14]
endmodule : drp_link
`default_nettype wire

// [src/drp_scale.sv]
`timescale 1ns/1ps
`default_nettype none
module drp_scale (
  input wire logic [31:0] steps,
  input wire logic [15:0] scale,
  input wire logic [31:0] ceil,
  output logic [31:0] user,
  output logic [31:0] clamped
);
  logic signed [48:0] prod; // steps times milli-units per step
  logic signed [31:0] u;
  logic signed [31:0] c;
  //////////////////////////////////////////////////////////////////////////////
  // [RQ8] saturate to signed range
  always_comb begin
    prod = $signed(steps) * $signed({1'b0, scale});
    if (prod > 49'sh0_0000_7fff_ffff) begin
      u = 32'sh7fffffff;
    end else if (prod < -49'sh0_0000_8000_0000) begin
      u = -32'sh7fffffff - 32'sh1;
    end else begin
      u = prod[31:0];
    end
    // [RQ9] ceiling clamp
    c = $signed(ceil);
    if (c < 0) begin
      c = 32'sh0; // negative ceiling treated as zero span
    end
    if (u > c) begin
      clamped = c;
    end else if (u < -c) begin
      clamped = -c;
    end else begin
      clamped = u;
    end
    user = u;
  end
endmodule : drp_scale
`default_nettype wire

// [dv/drp_drv_model.sv]
`timescale 1ns/1ps
`default_nettype none
// behavioural motor driver on the far side of the position link
module drp_drv_model
  import drp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic req_out,
  input wire logic transfer_clock_out,
  input wire drp_frame_t frame,
  input wire logic [3:0] lag,
  output logic driver_ready_in = 1'b0,
  output logic data_bit_low_in = 1'b0,
  output logic data_bit_high_in = 1'b0
);
  logic [5:0] k_ff = 6'h00; // next pair index
  logic [3:0] wait_ff = 4'h0; // ready delay
  logic ck_ff = 1'b0; // link clock last cycle
  // ready then pairs
  // pairs change on the falling clock so they are steady through the high phase
  always_ff @(posedge ref_clk) begin
    ck_ff <= transfer_clock_out;
    if (!req_out) begin
      k_ff <= 6'h00;
      wait_ff <= lag;
      driver_ready_in <= 1'b0;
      // idle lines toggle so a stale sample never looks valid
      data_bit_low_in <= ~data_bit_low_in;
      data_bit_high_in <= ~data_bit_high_in;
    end else if (!driver_ready_in) begin
      wait_ff <= wait_ff - 4'h1;
      if (wait_ff == 4'h0) begin
        driver_ready_in <= 1'b1;
        {data_bit_high_in, data_bit_low_in} <= frame[1:0];
        k_ff <= 6'h01;
      end
    end else if (ck_ff && !transfer_clock_out) begin
      {data_bit_high_in, data_bit_low_in} <= 2'(frame >> {k_ff, 1'b0});
      k_ff <= k_ff + 6'h01;
    end
  end
endmodule : drp_drv_model
`default_nettype wire

// [dv/drp_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module drp_top_bench
  import drp_pkg::*;
;
  localparam int SC = 3; // milli-units per step
  localparam logic [31:0] CL = 32'h00100000; // ceiling under test
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic pulse_gen_busy = 1'b0;
  logic [31:0] avs_readdata, rdata, tmp, up, c0, f0, e0, cn, fn;
  logic avs_waitrequest, irq, req_out, transfer_clock_out, position_data_ready_flag;
  logic driver_ready_in, data_bit_low_in, data_bit_high_in, positive_soft_limit, negative_soft_limit;
  logic [7:0] tpdo_bits;
  drp_frame_t frm = '0;
  logic [3:0] lag = 4'h2;
  logic [31:0] seed = 32'h70c2;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  drp_top #(.HALF(1)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .pulse_gen_busy(pulse_gen_busy),
    .driver_ready_in(driver_ready_in), .data_bit_low_in(data_bit_low_in), .data_bit_high_in(data_bit_high_in),
    .req_out(req_out), .transfer_clock_out(transfer_clock_out), .position_data_ready_flag(position_data_ready_flag),
    .tpdo_bits(tpdo_bits), .positive_soft_limit(positive_soft_limit), .negative_soft_limit(negative_soft_limit));
  drp_drv_model drv (.ref_clk(ref_clk), .req_out(req_out), .transfer_clock_out(transfer_clock_out), .frame(frm),
    .lag(lag), .driver_ready_in(driver_ready_in), .data_bit_low_in(data_bit_low_in),
    .data_bit_high_in(data_bit_high_in));
  always #20 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // hang guard, generous against the few hundred cycles needed
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 50) begin
      mismatches++;
      tally_and_finish();
    end
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // expected conversion, saturated to 32 bits signed
  function automatic logic [31:0] user_of(logic [31:0] p);
    longint v;
    v = longint'($signed(p)) * SC;
    if (v > 64'sh7fffffff) return 32'h7fffffff;
    if (v < -64'sh80000000) return 32'h80000000;
    return v[31:0];
  endfunction : user_of
  function automatic logic [31:0] clampc(logic [31:0] x);
    if ($signed(x) > $signed(CL)) return CL;
    if ($signed(x) < -$signed(CL)) return -CL;
    return x;
  endfunction : clampc
  // new random frame; the first one is a saturating extreme
  task automatic new_frame(input logic ext);
    tmp = rnd();
    frm = {ext ? 32'h80000001 : rnd(), tmp[15:0]};
    lag <= tmp[19:16];
    up = user_of(frm.pos);
  endtask : new_frame
  task automatic run_cmd(input logic [1:0] c);
    int n;
    n = 0;
    bus(1'b1, DRP_REG_CMD, {30'h0, c});
    repeat (2) @(posedge ref_clk);
    chk("ready_low", 32'h0, {31'h0, position_data_ready_flag});
    while (position_data_ready_flag !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk("ready_high", 32'h1, {31'h0, position_data_ready_flag});
    repeat (2) @(posedge ref_clk);
  endtask : run_cmd
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, DRP_REG_CEIL, 32'h0);
    chk("ceil_rst", DRP_CEIL_RST, rdata);
    bus(1'b0, DRP_REG_SCALE, 32'h0);
    chk("scale_rst", {16'h0, DRP_SCALE_RST}, rdata);
    bus(1'b0, 6'h3c, 32'h0);
    chk("unmapped", 32'h0, rdata);
    bus(1'b1, DRP_REG_SCALE, SC);
    bus(1'b1, DRP_REG_IMSK, 32'h1);
    bus(1'b1, DRP_REG_CEIL, CL);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      new_frame(i == 0);
      run_cmd(2'h1);
      bus(1'b0, DRP_REG_RPOS, 32'h0);
      chk("rpos", up, rdata);
      bus(1'b0, DRP_REG_RSTS, 32'h0);
      chk("rsts", {16'h0, frm.status, frm.alarm}, rdata);
      chk("irq_set", 32'h1, {31'h0, irq});
      bus(1'b0, DRP_REG_ISTS, 32'h0);
      chk("ists", 32'h1, rdata);
      repeat (2) @(posedge ref_clk);
      chk("irq_clr", 32'h0, {31'h0, irq});
    end
    $display("test plain done");
    new_frame(1'b0);
    // drive still de-energized for this adopt
    run_cmd(2'h2);
    bus(1'b0, DRP_REG_CPOS, 32'h0);
    chk("cpos_off", clampc(up), rdata);
    bus(1'b0, DRP_REG_FPOS, 32'h0);
    chk("fpos_off", clampc(up), rdata);
    chk("lim_off", 32'h0, {30'h0, positive_soft_limit, negative_soft_limit});
    bus(1'b1, DRP_REG_CFG, 32'h3);
    c0 = rnd() & 32'h000fffff;
    f0 = c0 - (rnd() & 32'hff);
    e0 = rnd();
    bus(1'b1, DRP_REG_CPOS, c0);
    bus(1'b1, DRP_REG_FPOS, f0);
    bus(1'b1, DRP_REG_ENC, e0);
    new_frame(1'b0);
    run_cmd(2'h2);
    cn = clampc(up);
    fn = clampc(cn - (c0 - f0));
    bus(1'b0, DRP_REG_CPOS, 32'h0);
    chk("cpos_on", cn, rdata);
    bus(1'b0, DRP_REG_FPOS, 32'h0);
    chk("fpos_on", fn, rdata);
    bus(1'b0, DRP_REG_ENC, 32'h0);
    chk("enc_on", e0 + fn - f0, rdata);
    chk("lim_on", 32'h3, {30'h0, positive_soft_limit, negative_soft_limit});
    // ready, home and both limits in the status word
    bus(1'b0, DRP_REG_STAT, 32'h0);
    chk("stat_home", 32'h39, rdata & 32'h39);
    $display("test adopt done");
    bus(1'b0, DRP_REG_ISTS, 32'h0);
    pulse_gen_busy <= 1'b1;
    bus(1'b1, DRP_REG_CMD, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus(1'b0, DRP_REG_ISTS, 32'h0);
    chk("reject", 32'h2, rdata);
    bus(1'b0, DRP_REG_CPOS, 32'h0);
    chk("cpos_kept", cn, rdata);
    new_frame(1'b0);
    run_cmd(2'h1);
    pulse_gen_busy <= 1'b0;
    $display("test reject done");
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, DRP_REG_CFG, 32'h0b | 32'(i << 4));
      repeat (3) @(posedge ref_clk);
      chk("tpdo", 32'h1 << i, {24'h0, tpdo_bits});
    end
    bus(1'b0, DRP_REG_RPOS, 32'h0);
    chk("rpos_kept", up, rdata);
    bus(1'b0, DRP_REG_RSTS, 32'h0);
    chk("rsts_kept", {16'h0, frm.status, frm.alarm}, rdata);
    $display("test map done");
    tally_and_finish();
  end
endmodule : drp_top_bench
`default_nettype wire
